// ---- verilog/adc_port_pkg.sv ----
package adc_port_pkg;

  // conversion word and serial timing
  localparam int WORD_BITS = 20;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int READY_GAP_CYC = 4;
  localparam int SELF_DIV = 4;
  localparam int SELF_HIGH_PHASE = 3;
  localparam int RELEASE_MAX_CYC = 4;
  localparam int HOST_HOLD_NS = 160;
  localparam int HOST_HOLD_CYC = READY_GAP_CYC + (HOST_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_INFO = 4'h2;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // event bits of status and mask
  localparam int EV_W = 4;
  localparam int EV_LOADED = 0;
  localparam int EV_SHIFTED = 1;
  localparam int EV_ABORTED = 2;
  localparam int EV_CAL = 3;

  // info register fields
  localparam int INFO_CAL_LSB = 0;
  localparam int INFO_MODE = 2;
  localparam int INFO_BUSY = 3;
  localparam int INFO_READY_N = 4;

  typedef struct packed {
    logic mode;
    logic standby_n;
    logic cal_select_b;
    logic cal_select_a;
    logic cal_trigger;
    logic shift_clk;
    logic select_n;
  } pin_in_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } port_state_t;

endpackage

// ---- verilog/pin_sync.sv ----
module pin_sync import adc_port_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pin_sync needs at least one bit");
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // pin_sync

// ---- verilog/port_regs.sv ----
module port_regs import adc_port_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  // block side
  input wire logic [EV_W-1:0] event_i,
  input wire logic [DATA_W-1:0] info_i,
  output logic irq_o
);
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] clear;

  assign clear = (wr_i && addr_i == REG_STATUS) ? wr_data_i[EV_W-1:0] : '0;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clear) | event_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mask_r <= MASK_RESET[EV_W-1:0];
    end else if (wr_i && addr_i == REG_MASK) begin
      mask_r <= wr_data_i[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status_r & ~clear) | event_i) & mask_r);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        REG_STATUS: rd_data_o <= {{(DATA_W-EV_W){1'b0}}, status_r};
        REG_MASK: rd_data_o <= {{(DATA_W-EV_W){1'b0}}, mask_r};
        REG_INFO: rd_data_o <= info_i;
        default: rd_data_o <= '0;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end
endmodule // port_regs

// ---- verilog/adc_serial_output_port.sv ----
// Design decisions made here: the plain strobed port and the address map.
module adc_serial_output_port import adc_port_pkg::*; #(
  parameter int WORD_W = WORD_BITS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // conversion word from the filter
  input wire logic [WORD_W-1:0] word_i,
  input wire logic word_valid_i,
  // pins from the host
  input wire logic mode_i,
  input wire logic standby_n_i,
  input wire logic select_n_i,
  input wire logic shift_clk_i,
  input wire logic cal_trigger_i,
  input wire logic cal_select_a_i,
  input wire logic cal_select_b_i,
  // pins to the host
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic shift_clk_o,
  output logic shift_clk_oe_o,
  output logic word_ready_n_o,
  // calibration control
  output logic [1:0] cal_type_o,
  output logic cal_start_o,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic irq_o
);
  localparam int CNT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);
  localparam logic [2:0] GAP_LOAD = 3'(READY_GAP_CYC);
  localparam logic [1:0] PH_HIGH = 2'(SELF_HIGH_PHASE);
  localparam logic [1:0] PH_PRE = 2'(SELF_HIGH_PHASE - 1);
  // synchronisers leave reset at the pins' idle levels, so no false select edge follows
  localparam pin_in_t PIN_IDLE = '{mode: 1'b0, standby_n: 1'b1, cal_select_b: 1'b0, cal_select_a: 1'b0,
                                   cal_trigger: 1'b0, shift_clk: 1'b0, select_n: 1'b1};

  generate
    if (WORD_W < 2 || SELF_DIV != 4) begin : g_bad
      $error("word must be at least two bits and the self clock divide four");
    end
  endgenerate

  pin_in_t pins_raw;
  pin_in_t pins;
  port_state_t state_r;
  logic [WORD_W-1:0] hold_r;
  logic [WORD_W-1:0] shift_r;
  logic have_word_r;
  logic [2:0] gap_cnt_r;
  logic ignore_r;
  logic self_mode_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [1:0] phase_r;
  logic sel_prev_r;
  logic sclk_prev_r;
  logic cal_prev_r;
  logic [EV_W-1:0] events;
  logic [DATA_W-1:0] info;
  logic sel_fall;
  logic sclk_fall;
  logic cal_rise;
  logic window;
  logic start;
  logic bit_end;
  logic last;
  logic deselected;

  assign pins_raw = '{mode: mode_i, standby_n: standby_n_i, cal_select_b: cal_select_b_i,
                      cal_select_a: cal_select_a_i, cal_trigger: cal_trigger_i,
                      shift_clk: shift_clk_i, select_n: select_n_i};

  pin_sync #(.WIDTH($bits(pin_in_t)), .RST_VAL(PIN_IDLE)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sel_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
      cal_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= pins.select_n;
      sclk_prev_r <= pins.shift_clk;
      cal_prev_r <= pins.cal_trigger;
    end
  end

  assign sel_fall = sel_prev_r & ~pins.select_n;
  assign sclk_fall = sclk_prev_r & ~pins.shift_clk;
  assign cal_rise = ~cal_prev_r & pins.cal_trigger;
  assign window = gap_cnt_r != 3'h0;
  assign deselected = pins.select_n;
  assign last = bit_cnt_r == LAST_BIT;
  // one bit ends on a host falling edge or at the end of the high phase
  assign bit_end = (state_r == ST_SHIFT) && (self_mode_r ? phase_r == PH_HIGH : sclk_fall);
  assign start = state_r == ST_IDLE && pins.standby_n && !pins.select_n && !ignore_r
                 && !(sel_fall && window) && have_word_r && !window;

  // word holding and the ready window
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_r <= '0;
      have_word_r <= 1'b0;
      gap_cnt_r <= 3'h0;
    end else if (!pins.standby_n) begin
      have_word_r <= 1'b0;
      gap_cnt_r <= 3'h0;
    end else if (word_valid_i) begin
      hold_r <= word_i;
      have_word_r <= 1'b1;
      gap_cnt_r <= GAP_LOAD;
    end else begin
      if (start) begin
        have_word_r <= 1'b0;
      end
      if (window) begin
        gap_cnt_r <= gap_cnt_r - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      word_ready_n_o <= 1'b1;
    end else begin
      word_ready_n_o <= !(have_word_r && !window && !start);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ignore_r <= 1'b0;
    end else if (deselected) begin
      ignore_r <= 1'b0;
    end else if (sel_fall && window && state_r == ST_IDLE) begin
      ignore_r <= 1'b1;
    end
  end

  // shift engine
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      shift_r <= '0;
      bit_cnt_r <= '0;
      phase_r <= 2'h0;
      self_mode_r <= 1'b0;
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      shift_clk_oe_o <= 1'b0;
    end else if (!pins.standby_n) begin
      state_r <= ST_IDLE;
      serial_out_oe_o <= 1'b0;
      shift_clk_oe_o <= 1'b0;
    end else if (start) begin
      state_r <= ST_SHIFT;
      shift_r <= hold_r << 1;
      bit_cnt_r <= '0;
      phase_r <= 2'h0;
      self_mode_r <= pins.mode;
      serial_out_o <= hold_r[WORD_W-1];
      serial_out_oe_o <= 1'b1;
      shift_clk_oe_o <= pins.mode;
    end else if (state_r == ST_SHIFT) begin
      phase_r <= phase_r + 2'h1;
      if (bit_end) begin
        if (last || deselected) begin
          state_r <= ST_IDLE;
          serial_out_oe_o <= 1'b0;
          shift_clk_oe_o <= 1'b0;
        end else begin
          bit_cnt_r <= bit_cnt_r + CNT_W'(1);
          serial_out_o <= shift_r[WORD_W-1];
          shift_r <= shift_r << 1;
        end
      end
    end
  end

  // self clock: high in the last of four phases
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      shift_clk_o <= 1'b0;
    end else begin
      shift_clk_o <= state_r == ST_SHIFT && self_mode_r && phase_r == PH_PRE && pins.standby_n;
    end
  end

  // calibration select latch
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cal_type_o <= 2'b00;
      cal_start_o <= 1'b0;
    end else begin
      cal_start_o <= cal_rise;
      if (cal_rise) begin
        cal_type_o <= {pins.cal_select_b, pins.cal_select_a};
      end
    end
  end

  always_comb begin
    events = '0;
    events[EV_LOADED] = word_valid_i && pins.standby_n;
    events[EV_SHIFTED] = bit_end && last;
    events[EV_ABORTED] = bit_end && !last && deselected;
    events[EV_CAL] = cal_rise;
    info = '0;
    info[INFO_CAL_LSB +: 2] = cal_type_o;
    info[INFO_MODE] = pins.mode;
    info[INFO_BUSY] = state_r == ST_SHIFT;
    info[INFO_READY_N] = word_ready_n_o;
  end

  port_regs u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .event_i(events),
    .info_i(info),
    .irq_o(irq_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  host_shift_a: assert property (bit_end && !self_mode_r && !last && !deselected && pins.standby_n
    |=> serial_out_o == $past(shift_r[WORD_W-1]) && bit_cnt_r == $past(bit_cnt_r) + CNT_W'(1))
    else $error("host falling edge did not present the next bit");

  early_release_a: assert property (bit_end && !self_mode_r && deselected && pins.standby_n
    |=> !serial_out_oe_o && !shift_clk_oe_o && state_r == ST_IDLE)
    else $error("early deselect did not float the port after the bit");

  ready_ignore_a: assert property (sel_fall && window && state_r == ST_IDLE
    |-> !start ##1 (ignore_r || deselected))
    else $error("select inside the ready window was taken");

  cal_latch_a: assert property (cal_rise
    |=> cal_type_o == $past({pins.cal_select_b, pins.cal_select_a}) && cal_start_o)
    else $error("calibration selects not latched at trigger edge");

  self_deselect_a: assert property (state_r == ST_SHIFT && self_mode_r && deselected && pins.standby_n
    |-> ##[1:4] !serial_out_oe_o)
    else $error("self mode data not floated within four cycles of deselect");

  final_release_a: assert property (shift_clk_o && last && state_r == ST_SHIFT
    |=> !serial_out_oe_o)
    else $error("data not floated one cycle after last rising edge");

  self_duty_a: assert property ($rose(shift_clk_o) |=> !shift_clk_o [*3])
    else $error("self shift clock high longer than one in four cycles");

  msb_first_a: assert property (start |=> serial_out_oe_o && serial_out_o == $past(hold_r[WORD_W-1]))
    else $error("transfer did not begin with the most significant bit");

  ready_gap_a: assert property (word_valid_i && pins.standby_n && !start
    |=> ##1 word_ready_n_o [*4])
    else $error("word ready low inside the four-cycle update window");

  ready_after_start_a: assert property (start |=> word_ready_n_o)
    else $error("word ready still low after the transfer took the word");

  standby_drop_a: assert property (!pins.standby_n
    |=> !serial_out_oe_o && !shift_clk_oe_o ##1 word_ready_n_o)
    else $error("standby did not float the port and drop the held word");

  ext_clock_in_a: assert property (state_r == ST_SHIFT && !self_mode_r
    |-> !shift_clk_oe_o && !shift_clk_o)
    else $error("shift clock driven during an external clock transfer");

  port_drive_a: assert property (state_r == ST_SHIFT
    |-> serial_out_oe_o && shift_clk_oe_o == self_mode_r)
    else $error("port drive enables do not follow the transfer mode");

  self_period_a: assert property ($rose(shift_clk_o) && !last && !deselected && pins.standby_n
    |-> ##4 (shift_clk_o || !shift_clk_oe_o))
    else $error("self shift clock not at one quarter of the master clock");

endmodule // adc_serial_output_port

// ---- testbench/host_model.sv ----
module host_model import adc_port_pkg::*; (
  // clock
  input wire logic ref_clk_i,
  // device pins
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i,
  input wire logic shift_clk_i,
  input wire logic shift_clk_oe_i,
  // host pins
  output logic select_n_o,
  output logic shift_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    select_n_o = 1'b1;
    shift_clk_o = 1'b0;
  end

  // host clocked read of nbits at 160 ns per bit, deselecting after the last one
  task automatic ext_read(input int nbits, output logic [WORD_BITS-1:0] w);
    w = '0;
    @(posedge ref_clk_i);
    select_n_o <= 1'b0;
    repeat (HOST_HOLD_CYC + 2) @(posedge ref_clk_i);
    #3;
    for (int i = 0; i < nbits; i++) begin
      shift_clk_o = 1'b1;
      // a floated line reads as unknown so a release never passes for data
      w = {w[WORD_BITS-2:0], serial_out_oe_i ? serial_out_i : 1'bx};
      #80;
      if (i == nbits - 1) select_n_o = 1'b1;
      shift_clk_o = 1'b0;
      #80;
    end
  endtask

  // device clocked read: data taken while the device shift clock is high
  task automatic self_read(output logic [WORD_BITS-1:0] w, output int bits, output int highs, output int span);
    logic last;
    w = '0;
    bits = 0;
    highs = 0;
    span = 0;
    last = 1'b0;
    @(posedge ref_clk_i);
    select_n_o <= 1'b0;
    for (int i = 0; i < 300 && (span == 0 || shift_clk_oe_i); i++) begin
      @(posedge ref_clk_i);
      #1;
      if (shift_clk_oe_i) begin
        span++;
        highs += shift_clk_i;
        if (shift_clk_i && !last) begin
          bits++;
          w = {w[WORD_BITS-2:0], serial_out_oe_i ? serial_out_i : 1'bx};
        end
      end
      last = shift_clk_i;
    end
    select_n_o <= 1'b1;
  endtask
endmodule // host_model

// ---- testbench/test_adc_serial_output_port.sv ----
module test_adc_serial_output_port import adc_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_i = 1'b0;
  logic rst_n_i, word_valid_i, mode_i, standby_n_i, cal_trigger_i, cal_select_a_i, cal_select_b_i, wr_i, rd_i;
  logic [WORD_BITS-1:0] word_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i, rd_data_o;
  logic select_n, shift_clk, serial_out_o, serial_out_oe_o, shift_clk_o, shift_clk_oe_o, word_ready_n_o;
  logic cal_start_o, irq_o;
  logic [1:0] cal_type_o;
  int mismatches = 0;
  int checked = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  adc_serial_output_port adc_serial_output_port_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .word_i(word_i), .word_valid_i(word_valid_i),
    .mode_i(mode_i), .standby_n_i(standby_n_i), .select_n_i(select_n), .shift_clk_i(shift_clk),
    .cal_trigger_i(cal_trigger_i), .cal_select_a_i(cal_select_a_i), .cal_select_b_i(cal_select_b_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .shift_clk_o(shift_clk_o),
    .shift_clk_oe_o(shift_clk_oe_o), .word_ready_n_o(word_ready_n_o), .cal_type_o(cal_type_o),
    .cal_start_o(cal_start_o), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .irq_o(irq_o));

  host_model host_model_inst (
    .ref_clk_i(ref_clk_i), .serial_out_i(serial_out_o), .serial_out_oe_i(serial_out_oe_o),
    .shift_clk_i(shift_clk_o), .shift_clk_oe_i(shift_clk_oe_o), .select_n_o(select_n), .shift_clk_o(shift_clk));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic load(input logic [19:0] w);
    @(posedge ref_clk_i);
    word_i <= w;
    word_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    word_valid_i <= 1'b0;
  endtask

  task automatic set_mode(input logic m);
    @(posedge ref_clk_i);
    mode_i <= m;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic t_reset();
    logic [7:0] s;
    check(word_ready_n_o, 1'b1);
    check({serial_out_oe_o, shift_clk_oe_o, irq_o}, 3'b000);
    rd(REG_STATUS, s);
    check(s, 8'h00);
    rd(REG_MASK, s);
    check(s, MASK_RESET);
    $display("reset test done");
  endtask

  task automatic t_cal();
    logic [7:0] s;
    int n;
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk_i);
      cal_select_a_i <= c[0];
      cal_select_b_i <= c[1];
      repeat (3) @(posedge ref_clk_i);
      cal_trigger_i <= 1'b1;
      n = 0;
      repeat (8) begin
        @(posedge ref_clk_i);
        #1;
        n += cal_start_o;
      end
      check(cal_type_o, c[1:0]);
      check(n, 1);
      @(posedge ref_clk_i);
      cal_select_a_i <= ~c[0];
      cal_select_b_i <= ~c[1];
      cal_trigger_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      check(cal_type_o, c[1:0]);
    end
    rd(REG_STATUS, s);
    check(s, 8'h08);
    rd(REG_INFO, s);
    check(s, 8'h13);
    wr(REG_INFO, 8'hFF);
    rd(REG_INFO, s);
    check(s, 8'h13);
    rd(4'hF, s);
    check(s, 8'h00);
    $display("calibration test done");
  endtask

  task automatic t_ext();
    logic [19:0] w;
    logic [7:0] s;
    set_mode(1'b0);
    wr(REG_STATUS, 8'h0F);
    wr(REG_MASK, 8'h02);
    @(posedge ref_clk_i);
    word_i <= 20'hA5C3E;
    word_valid_i <= 1'b1;
    host_model_inst.select_n_o <= 1'b0;
    @(posedge ref_clk_i);
    word_valid_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    check(serial_out_oe_o, 1'b0);
    host_model_inst.select_n_o <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check(word_ready_n_o, 1'b0);
    host_model_inst.ext_read(WORD_BITS, w);
    check(w, 20'hA5C3E);
    check({serial_out_oe_o, word_ready_n_o, irq_o}, 3'b011);
    wr(REG_STATUS, 8'h02);
    @(posedge ref_clk_i);
    #1;
    check(irq_o, 1'b0);
    rd(REG_STATUS, s);
    check(s, 8'h01);
    $display("external clock test done");
  endtask

  task automatic t_self();
    logic [19:0] w;
    int bits, highs, span;
    set_mode(1'b1);
    load(20'h3C5A9);
    repeat (10) @(posedge ref_clk_i);
    host_model_inst.self_read(w, bits, highs, span);
    check(w, 20'h3C5A9);
    check(bits, WORD_BITS);
    check(highs, WORD_BITS);
    check(span, WORD_BITS * SELF_DIV);
    $display("self clock test done");
  endtask

  task automatic t_abort();
    logic [19:0] w;
    logic [7:0] s;
    int n;
    set_mode(1'b0);
    wr(REG_STATUS, 8'h0F);
    load(20'h96F0F);
    repeat (10) @(posedge ref_clk_i);
    host_model_inst.ext_read(5, w);
    check(w[4:0], 5'h12);
    check({serial_out_oe_o, shift_clk_oe_o}, 2'b00);
    rd(REG_STATUS, s);
    check(s, 8'h05);
    // self clock transfer cut after a few bits
    set_mode(1'b1);
    wr(REG_STATUS, 8'h0F);
    load(20'h4B2D1);
    repeat (10) @(posedge ref_clk_i);
    host_model_inst.select_n_o <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    check(serial_out_oe_o, 1'b1);
    host_model_inst.select_n_o <= 1'b1;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk_i);
      #1;
      n += serial_out_oe_o;
    end
    // two synchroniser cycles before the deselect is seen
    check(n <= RELEASE_MAX_CYC + 2, 1'b1);
    check({serial_out_oe_o, shift_clk_oe_o}, 2'b00);
    rd(REG_STATUS, s);
    check(s, 8'h05);
    $display("early deselect test done");
  endtask

  task automatic t_standby();
    logic [7:0] s;
    rd(REG_INFO, s);
    check(s, 8'h17);
    load(20'h5A5A5);
    repeat (10) @(posedge ref_clk_i);
    check(word_ready_n_o, 1'b0);
    host_model_inst.select_n_o <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    check({serial_out_oe_o, shift_clk_oe_o}, 2'b11);
    standby_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    check({serial_out_oe_o, shift_clk_oe_o, shift_clk_o, word_ready_n_o}, 4'b0001);
    @(posedge ref_clk_i);
    host_model_inst.select_n_o <= 1'b1;
    wr(REG_STATUS, 8'h0F);
    // a word offered in standby is dropped
    load(20'h12345);
    @(posedge ref_clk_i);
    standby_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    #1;
    check(word_ready_n_o, 1'b1);
    rd(REG_STATUS, s);
    check(s, 8'h00);
    $display("standby test done");
  endtask

  initial begin
    rst_n_i = 1'b0;
    word_i = '0;
    word_valid_i = 1'b0;
    mode_i = 1'b0;
    standby_n_i = 1'b1;
    cal_trigger_i = 1'b0;
    cal_select_a_i = 1'b0;
    cal_select_b_i = 1'b0;
    addr_i = '0;
    wr_data_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_cal();
    t_ext();
    t_self();
    t_abort();
    t_standby();
    give_verdict();
  end

  // the tests need some 800 cycles; far longer means a hang
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end
endmodule // test_adc_serial_output_port
